// file: include/ocp_map.vh
// Register offsets, field positions, reset values and mode codes of the compare unit
`ifndef OCP_MAP_VH
`define OCP_MAP_VH

`define OCP_ADDR_W          8
`define OCP_OFS_CTRL        8'h00
`define OCP_OFS_CTRL_CLR    8'h04
`define OCP_OFS_CTRL_SET    8'h08
`define OCP_OFS_CTRL_INV    8'h0c
`define OCP_OFS_PRIMARY     8'h10
`define OCP_OFS_SECONDARY   8'h20
`define OCP_OFS_IRQ_STATUS  8'h30
`define OCP_OFS_IRQ_MASK    8'h34

`define OCP_BIT_ENABLE      15
`define OCP_BIT_IDLE_STOP   13
`define OCP_BIT_WIDE        5
`define OCP_BIT_FAULT       4
`define OCP_BIT_TSEL        3
`define OCP_MODE_HI         2
`define OCP_MODE_LO         0
`define OCP_CTRL_WMASK      32'h0000a02f

`define OCP_CTRL_RESET      32'h00000000
`define OCP_VALUE_RESET     32'h00000000

`define OCP_MODE_OFF        3'h0
`define OCP_MODE_RISE       3'h1
`define OCP_MODE_FALL       3'h2
`define OCP_MODE_TOGGLE     3'h3
`define OCP_MODE_ONE_PULSE  3'h4
`define OCP_MODE_PULSES     3'h5
`define OCP_MODE_PWM        3'h6
`define OCP_MODE_PWM_FAULT  3'h7

`define OCP_IRQ_W           3
`define OCP_IRQ_PRIMARY     0
`define OCP_IRQ_SECONDARY   1
`define OCP_IRQ_FAULT       2

`endif

// file: logic/ocp_match.v
// Compare of the selected timer count against one compare value, 16 or 32 bits wide
`timescale 1ns/1ns
`default_nettype none

module ocp_match (
  // Operands
  input  wire [31:0] count,
  input  wire [31:0] value,
  input  wire        wide,
  // Result
  output wire        hit
);

  // Narrow mode ignores the upper halves of both operands
  assign hit = wide ? (count == value) : (count[15:0] == value[15:0]);

endmodule

`default_nettype wire

// file: logic/ocp_unit.v
// Output compare unit with single-edge, toggle, pulse and PWM modes and a register port
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ocp_map.vh"

module ocp_unit (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  // Timer counts and processor state
  input  wire [31:0] timer_x_count,
  input  wire [31:0] timer_y_count,
  input  wire        cpu_idle,
  // Fault pin, active low
  input  wire        fault_n,
  // Compare output pin and interrupt
  output reg         compare_output_pin,
  output wire        irq
);

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  reg fault_meta_n;
  reg fault_sync_n;

  always @(posedge clock) begin
    if (reset) begin
      fault_meta_n <= 1'b1;
      fault_sync_n <= 1'b1;
    end else begin
      fault_meta_n <= fault_n;
      fault_sync_n <= fault_meta_n;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [31:0]           compare_control;
  reg  [31:0]           primary_compare_value;
  reg  [31:0]           secondary_compare_value;
  reg  [`OCP_IRQ_W-1:0] irq_status;
  reg  [`OCP_IRQ_W-1:0] irq_mask;
  reg                   pwm_fault_flag;
  reg  [31:0]           next_control;

  wire [2:0] compare_mode_field = compare_control[`OCP_MODE_HI:`OCP_MODE_LO];
  wire       enable             = compare_control[`OCP_BIT_ENABLE];
  wire       idle_stop          = compare_control[`OCP_BIT_IDLE_STOP];
  wire       wide_compare_select = compare_control[`OCP_BIT_WIDE];
  wire       timebase_select    = compare_control[`OCP_BIT_TSEL];

  function is_pwm;
    input [2:0] mode;
    begin
      is_pwm = (mode == `OCP_MODE_PWM) || (mode == `OCP_MODE_PWM_FAULT);
    end
  endfunction

  function uses_secondary;
    input [2:0] mode;
    begin
      uses_secondary = mode[2];
    end
  endfunction

  // Alias writes touch only implemented writable bits
  always @* begin
    next_control = compare_control;
    case (reg_addr)
      `OCP_OFS_CTRL:     next_control = reg_wdata;
      `OCP_OFS_CTRL_CLR: next_control = compare_control & ~reg_wdata;
      `OCP_OFS_CTRL_SET: next_control = compare_control | reg_wdata;
      `OCP_OFS_CTRL_INV: next_control = compare_control ^ reg_wdata;
      default:           next_control = compare_control;
    endcase
    next_control = next_control & `OCP_CTRL_WMASK;
  end

  wire ctrl_hit = (reg_addr == `OCP_OFS_CTRL) || (reg_addr == `OCP_OFS_CTRL_CLR) ||
                  (reg_addr == `OCP_OFS_CTRL_SET) || (reg_addr == `OCP_OFS_CTRL_INV);

  // ---------------------------------------------------------------
  // Compare engine
  // ---------------------------------------------------------------
  wire        running = enable && !(idle_stop && cpu_idle);
  wire [31:0] count   = timebase_select ? timer_y_count : timer_x_count;
  wire        hit_primary;
  wire        hit_secondary;
  reg  [31:0] count_seen;
  reg         seen_valid;

  ocp_match u_match_primary (
    .count (count),
    .value (primary_compare_value),
    .wide  (wide_compare_select),
    .hit   (hit_primary)
  );

  ocp_match u_match_secondary (
    .count (count),
    .value (secondary_compare_value),
    .wide  (wide_compare_select),
    .hit   (hit_secondary)
  );

  // A timer that sits on a matching value gives one event, not one per cycle
  wire count_moved = !seen_valid || (count != count_seen);
  wire ev_primary   = running && count_moved && hit_primary;
  wire ev_secondary = running && count_moved && hit_secondary &&
                      uses_secondary(compare_mode_field);
  wire fault_now    = running && !fault_sync_n &&
                      (compare_mode_field == `OCP_MODE_PWM_FAULT);

  reg [2:0] mode_seen;
  reg       pulse_done;
  wire      mode_change = (compare_mode_field != mode_seen);

  always @(posedge clock) begin
    if (reset) begin
      count_seen <= 32'h00000000;
      seen_valid <= 1'b0;
    end else begin
      count_seen <= count;
      seen_valid <= running;
    end
  end

  // Output pin state; a mode change reinitialises the pin level, except a change to toggle mode, which keeps it
  always @(posedge clock) begin
    if (reset) begin
      compare_output_pin <= 1'b0;
      mode_seen          <= `OCP_MODE_OFF;
      pulse_done         <= 1'b0;
    end else begin
      mode_seen <= compare_mode_field;
      if (!enable) begin
        compare_output_pin <= 1'b0;
        pulse_done         <= 1'b0;
        // Forget the mode so that turning on re-runs its pin start-up level
        mode_seen          <= `OCP_MODE_OFF;
      end else if (mode_change) begin
        pulse_done <= 1'b0;
        case (compare_mode_field)
          `OCP_MODE_FALL:     compare_output_pin <= 1'b1;
          `OCP_MODE_TOGGLE:   compare_output_pin <= compare_output_pin;
          default:            compare_output_pin <= 1'b0;
        endcase
      end else begin
        case (compare_mode_field)
          `OCP_MODE_OFF: begin
            compare_output_pin <= compare_output_pin;
          end
          `OCP_MODE_RISE: begin
            if (ev_primary) begin
              compare_output_pin <= 1'b1;
            end
          end
          `OCP_MODE_FALL: begin
            if (ev_primary) begin
              compare_output_pin <= 1'b0;
            end
          end
          `OCP_MODE_TOGGLE: begin
            if (ev_primary) begin
              compare_output_pin <= !compare_output_pin;
            end
          end
          `OCP_MODE_ONE_PULSE: begin
            if (ev_primary && !pulse_done && !compare_output_pin) begin
              compare_output_pin <= 1'b1;
            end else if (ev_secondary && compare_output_pin) begin
              compare_output_pin <= 1'b0;
              pulse_done         <= 1'b1;
            end
          end
          `OCP_MODE_PULSES: begin
            if (ev_primary) begin
              compare_output_pin <= 1'b1;
            end else if (ev_secondary) begin
              compare_output_pin <= 1'b0;
            end
          end
          default: begin
            // PWM: high from the primary match, low at the secondary match
            if (fault_now || pwm_fault_flag) begin
              compare_output_pin <= 1'b0;
            end else if (ev_primary) begin
              compare_output_pin <= 1'b1;
            end else if (ev_secondary) begin
              compare_output_pin <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Fault flag is cleared by hardware only, when fault mode is left or the unit turned off
  always @(posedge clock) begin
    if (reset) begin
      pwm_fault_flag <= 1'b0;
    end else if (fault_now) begin
      pwm_fault_flag <= 1'b1;
    end else if (!enable || compare_mode_field != `OCP_MODE_PWM_FAULT) begin
      pwm_fault_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      compare_control         <= `OCP_CTRL_RESET;
      primary_compare_value   <= `OCP_VALUE_RESET;
      secondary_compare_value <= `OCP_VALUE_RESET;
      irq_mask                <= {`OCP_IRQ_W{1'b0}};
    end else if (reg_write) begin
      if (ctrl_hit) begin
        compare_control <= next_control;
      end
      if (reg_addr == `OCP_OFS_PRIMARY) begin
        primary_compare_value <= reg_wdata;
      end
      if (reg_addr == `OCP_OFS_SECONDARY) begin
        secondary_compare_value <= reg_wdata;
      end
      if (reg_addr == `OCP_OFS_IRQ_MASK) begin
        irq_mask <= reg_wdata[`OCP_IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  wire [`OCP_IRQ_W-1:0] irq_events = {fault_now, ev_secondary, ev_primary};
  wire                  status_rd  = reg_read && (reg_addr == `OCP_OFS_IRQ_STATUS);

  // Read clears; an event in the same cycle survives the clear
  always @(posedge clock) begin
    if (reset) begin
      irq_status <= {`OCP_IRQ_W{1'b0}};
    end else if (status_rd) begin
      irq_status <= irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  reg [31:0] read_value;

  always @* begin
    read_value = 32'h00000000;
    case (reg_addr)
      `OCP_OFS_CTRL, `OCP_OFS_CTRL_CLR, `OCP_OFS_CTRL_SET, `OCP_OFS_CTRL_INV: begin
        read_value = compare_control & `OCP_CTRL_WMASK;
        read_value[`OCP_BIT_FAULT] = pwm_fault_flag &&
          (compare_mode_field == `OCP_MODE_PWM_FAULT);
      end
      `OCP_OFS_PRIMARY:    read_value = primary_compare_value;
      `OCP_OFS_SECONDARY:  read_value = secondary_compare_value;
      `OCP_OFS_IRQ_STATUS: read_value = {29'h0, irq_status};
      `OCP_OFS_IRQ_MASK:   read_value = {29'h0, irq_mask};
      default:             read_value = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      reg_rdata <= read_value;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// file: tb/ocp_checker.sv
// Port-level assertions of the compare unit
`timescale 1ns/1ns
`default_nettype none
module ocp_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // Timers, idle, fault
  input wire logic [31:0] timer_x_count,
  input wire logic [31:0] timer_y_count,
  input wire logic        cpu_idle,
  input wire logic        fault_n,
  // Outputs
  input wire logic        compare_output_pin,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire rd_ctl = reg_read && reg_addr == 8'h00;
  a_unmapped_reads_zero: assert property (reg_read && reg_addr == 8'h40
    |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_reserved_bits_zero: assert property (rd_ctl |=> (reg_rdata & 32'hffff5fc0) == 32'h0)
    else $error("reserved control bits set");
  a_flag_only_pwm: assert property (rd_ctl |=> !reg_rdata[4] || reg_rdata[2:0] == 3'h7)
    else $error("fault flag outside fault mode");
  a_off_pin_low: assert property (rd_ctl ##1 !reg_rdata[15] |=> !compare_output_pin)
    else $error("pin high while disabled");
  a_fault_pin_low: assert property (rd_ctl ##1 reg_rdata[4] |-> !compare_output_pin)
    else $error("pin high during fault");
  a_mode_off_quiet: assert property (rd_ctl ##1 reg_rdata[15] && reg_rdata[2:0] == 3'h0
    |-> !compare_output_pin)
    else $error("pin active in mode off");
  a_irq_masked_off: assert property (reg_read && reg_addr == 8'h34
    ##1 reg_rdata[2:0] == 3'h0 |-> !irq)
    else $error("irq with empty mask");
  a_alias_mirror: assert property (rd_ctl ##2 reg_read && reg_addr == 8'h0c
    |=> reg_rdata == $past(reg_rdata, 2))
    else $error("alias read differs");
  cover property (rd_ctl ##1 reg_rdata[4]);
  cover property ($rose(compare_output_pin));
  cover property ($rose(irq));
endmodule
bind ocp_unit ocp_checker chk (.clock(clock), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .timer_x_count(timer_x_count), .timer_y_count(timer_y_count), .cpu_idle(cpu_idle),
  .fault_n(fault_n), .compare_output_pin(compare_output_pin), .irq(irq));
`default_nettype wire

// file: tb/ocp_timer_model.sv
// Timer pair feeding the compare unit, wrapping every PERIOD counts
`timescale 1ns/1ns
`default_nettype none
module ocp_timer_model #(
  parameter PERIOD = 32
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Counts
  output var  logic [31:0] count_x,
  output wire logic [31:0] count_y
);
  // Timer y sits 64K above x, so only a wide compare tells them apart
  assign count_y = count_x | 32'h00010000;
  always @(posedge clock) begin
    if (reset || count_x == PERIOD - 1) begin
      count_x <= 32'h0;
    end else begin
      count_x <= count_x + 32'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_output_compare_pwm_unit.sv
// Self-checking bench of the compare unit
`timescale 1ns/1ns
`default_nettype none
module test_output_compare_pwm_unit;
  logic        clock     = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  reg_addr  = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic        cpu_idle  = 1'b0;
  logic        fault_n   = 1'b1;
  wire  [31:0] reg_rdata;
  wire  [31:0] tx;
  wire  [31:0] ty;
  wire         pin;
  wire         irq;
  logic [31:0] d;
  logic [3:0]  m;
  integer      num_errors  = 0;
  integer      checks_done = 0;
  integer      cycles      = 0;
  // Pin after primary, after secondary, after next primary, bit per mode
  localparam logic [7:0] P1 = 8'hfa;
  localparam logic [7:0] S1 = 8'h0a;
  localparam logic [7:0] P2 = 8'he2;
  always #4 clock = ~clock;
  ocp_timer_model #(.PERIOD(32)) tmr (.clock(clock), .reset(reset), .count_x(tx), .count_y(ty));
  ocp_unit uut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_x_count(tx),
    .timer_y_count(ty), .cpu_idle(cpu_idle), .fault_n(fault_n),
    .compare_output_pin(pin), .irq(irq));
  task conclude;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clock);
  endtask
  task expect_reg(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    check(d, e);
  endtask
  task pin_is(input logic e);
    check({31'h0, pin}, {31'h0, e});
  endtask
  // Bounded wait for a timer count, then let the pin settle
  task at(input logic [31:0] v);
    integer n;
    n = 0;
    while (tx !== v && n < 64) begin
      @(posedge clock);
      n = n + 1;
    end
    repeat (2) @(posedge clock);
  endtask
  task go(input logic [31:0] c);
    at(32'd26);
    wr(8'h00, 32'h0);
    wr(8'h00, c);
  endtask
  task try_mode(input logic [31:0] c, input logic e);
    go(c);
    at(32'd12);
    pin_is(e);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    pin_is(1'b0);
    expect_reg(8'h00, 32'h0);
    expect_reg(8'h34, 32'h0);
    expect_reg(8'h40, 32'h0);
    wr(8'h00, 32'hffffffff);
    expect_reg(8'h00, 32'h0000a02f);
    wr(8'h04, 32'h0000002e);
    expect_reg(8'h00, 32'h0000a001);
    wr(8'h08, 32'h00000008);
    wr(8'h0c, 32'h0000a003);
    expect_reg(8'h00, 32'h0000000a);
    expect_reg(8'h0c, 32'h0000000a);
    wr(8'h10, 32'h0001000a);
    wr(8'h20, 32'h0001000f);
    wr(8'h08, 32'h00008000);
    expect_reg(8'h00, 32'h0000800a);
    pin_is(1'b1);
    for (m = 4'h0; m < 4'h8; m = m + 4'h1) begin
      go({28'h0000800, 1'b0, m[2:0]});
      expect_reg(8'h00, {28'h0000800, 1'b0, m[2:0]});
      pin_is(m == 4'h2);
      at(32'd12);
      pin_is(P1[m[2:0]]);
      at(32'd17);
      pin_is(S1[m[2:0]]);
      at(32'd12);
      pin_is(P2[m[2:0]]);
    end
    try_mode(32'h00008021, 1'b0);
    try_mode(32'h00008029, 1'b1);
    try_mode(32'h00008009, 1'b1);
    cpu_idle <= 1'b1;
    try_mode(32'h0000a001, 1'b0);
    try_mode(32'h00008001, 1'b1);
    cpu_idle <= 1'b0;
    wr(8'h34, 32'h00000004);
    go(32'h00008007);
    rd(8'h30, d);
    fault_n <= 1'b0;
    at(32'd12);
    fault_n <= 1'b1;
    expect_reg(8'h00, 32'h00008017);
    pin_is(1'b0);
    check({31'h0, irq}, 32'h1);
    wr(8'h00, 32'h00008007);
    expect_reg(8'h00, 32'h00008017);
    wr(8'h00, 32'h00008006);
    fault_n <= 1'b0;
    expect_reg(8'h00, 32'h00008006);
    rd(8'h30, d);
    check(d & 32'h4, 32'h4);
    at(32'd12);
    pin_is(1'b1);
    check({31'h0, irq}, 32'h0);
    wr(8'h34, 32'h0);
    expect_reg(8'h34, 32'h0);
    fault_n <= 1'b1;
    wr(8'h00, 32'h0);
    expect_reg(8'h00, 32'h0);
    conclude;
  end
endmodule
`default_nettype wire
